// File: poe_port_power_allocator.v
/*
 * Port power allocator: APB command slave, per-port mode and grant store,
 * and a scanner that walks the ports one per cycle to grant, shed and rearm.
 * Assumes the port controllers present request and consumption of the port
 * named by scan_port on the same clock, and detect/open as async pin levels.
 */
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "poe_alloc_map.vh"

module poe_port_power_allocator #(
	parameter NPORTS = 48,
	parameter PW = 16,
	parameter SW = 24
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NPORTS-1:0] pd_present_in,
	input wire [NPORTS-1:0] pd_open_in,
	input wire [PW-1:0] scan_req_mw,
	input wire [PW-1:0] scan_cons_mw,
	output reg [5:0] scan_port,
	output reg [NPORTS-1:0] port_power_en,
	output reg site_midspan
);
	localparam TW = SW + 2;
	localparam HW = 12;
	localparam [HW-1:0] HOLD_EP = `BACKOFF_EP_CYC;
	localparam [HW-1:0] HOLD_MS = `BACKOFF_MS_CYC;
	localparam [5:0] LAST = NPORTS - 1;

	// Pin synchronisers for detect and open levels
	reg [NPORTS-1:0] pres_m_r;
	reg [NPORTS-1:0] pres_s_r;
	reg [NPORTS-1:0] open_m_r;
	reg [NPORTS-1:0] open_s_r;

	// Per-port state
	reg [PW-1:0] grant_r [0:NPORTS-1]; // Granted power
	reg [PW-1:0] cons_r [0:NPORTS-1]; // Last consumption seen
	reg [1:0] mode_r [0:NPORTS-1]; // Control mode
	reg [1:0] prio_r [0:NPORTS-1]; // Configured priority
	reg [2:0] stat_r [0:NPORTS-1]; // Reported status
	reg [NPORTS-1:0] en_r; // Port allowed to power
	reg [NPORTS-1:0] blk_r; // Waiting for reconnect

	// System settings
	reg [SW-1:0] supply_r [0:2]; // Supply outputs in mW
	reg [6:0] reserve_r; // Reserve percent
	reg [6:0] surge_r; // Overload limit percent
	reg alloc_r; // Allocation policy
	reg [1:0] rearm_r; // Rearm policy

	// Sums and command answer
	reg [TW-1:0] gsum_r; // Total granted
	reg [TW-1:0] csum_r; // Total consumed
	reg [31:0] arg_r; // Command argument
	reg [31:0] cmdw_r; // Last command word
	reg [7:0] result_r; // Command answer
	reg [31:0] rdat_r; // Query answer

	// Sweep control
	reg [HW-1:0] hold_r; // Back-off timer
	reg shed_done_r; // One shed per sweep
	reg [1:0] shed_lvl_r; // Priority level now being shed
	reg want_v_r; // A denied port waits this sweep
	reg [1:0] want_r; // Highest denied priority this sweep
	reg want_cur_v_r; // Preemption armed from last sweep
	reg [1:0] want_cur_r; // Priority allowed to preempt

	// Bus strobes
	wire acc = psel & penable;
	wire cmd_go = acc & pwrite & (paddr == `OFS_CMD);
	wire mapped = (paddr == `OFS_CMD) || (paddr == `OFS_ARG) || (paddr == `OFS_RESULT) ||
		(paddr == `OFS_RDATA) || (paddr == `OFS_SUM_GRANT) || (paddr == `OFS_SUM_CONS) ||
		(paddr == `OFS_SUM_PROV);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// Totals and policy arithmetic
	wire [TW-1:0] prov = {2'h0, supply_r[0]} + {2'h0, supply_r[1]} + {2'h0, supply_r[2]};
	wire [5:0] p = scan_port;
	wire [TW-1:0] req_w = {{(TW-PW){1'b0}}, scan_req_mw};
	wire [33:0] prov_free = prov * (`PCT_MAX - reserve_r);
	wire [33:0] cons_need = (csum_r + req_w) * 7'h64;
	wire fits = (alloc_r == `ALLOC_GRANT) ? ({1'b0, prov} >= {1'b0, gsum_r} + {1'b0, req_w}) :
		(prov_free >= cons_need);
	wire overload = csum_r > prov;
	wire [33:0] excess = (csum_r - prov) * 7'h64;
	wire [33:0] tolerate = prov * surge_r;
	wire severe = overload && (excess > tolerate);

	// Scanner decision for the port under scan
	reg [1:0] act_prio;
	reg op_on;
	reg op_off;
	reg op_clr_en;
	reg op_set_blk;
	reg op_clr_blk;
	reg op_shed;
	reg op_deny;
	reg [2:0] st_nxt;
	always @* begin
		act_prio = prio_r[p];
		op_on = 1'b0;
		op_off = 1'b0;
		op_clr_en = 1'b0;
		op_set_blk = 1'b0;
		op_clr_blk = 1'b0;
		op_shed = 1'b0;
		op_deny = 1'b0;
		st_nxt = stat_r[p];
		// Forced modes lift low and high to the forced level
		if (mode_r[p] != `MODE_AUTO && prio_r[p] < `PRIO_FORCED)
			act_prio = `PRIO_FORCED;
		if (!en_r[p]) begin
			// Disabled: off until re-enabled by command
			op_off = port_power_en[p];
			st_nxt = `ST_DISABLED;
		end else if (mode_r[p] == `MODE_FORCE_OFF) begin
			// Forced off beats every other condition except disable
			op_off = port_power_en[p];
			st_nxt = `ST_FORCED_OFF;
		end else if (port_power_en[p] && scan_cons_mw > grant_r[p]) begin
			// Port overload
			op_off = 1'b1;
			if (rearm_r == `REARM_RECONNECT) begin
				op_set_blk = 1'b1;
				st_nxt = `ST_BLOCKED;
			end else if (rearm_r == `REARM_REENABLE) begin
				op_clr_en = 1'b1;
				st_nxt = `ST_DISABLED;
			end else begin
				st_nxt = `ST_POWERED_OFF;
			end
		end else if (blk_r[p]) begin
			// Blocked until an open circuit is seen
			st_nxt = `ST_BLOCKED;
			op_clr_blk = open_s_r[p];
		end else if (port_power_en[p] && severe && act_prio == `PRIO_LOW) begin
			// Severe overload drops every low port
			op_off = 1'b1;
			st_nxt = `ST_DENIED;
		end else if (port_power_en[p] && overload && !severe && !shed_done_r && act_prio <= shed_lvl_r) begin
			// Mild overload sheds a single port per sweep, lowest level first
			op_off = 1'b1;
			op_shed = 1'b1;
			st_nxt = `ST_DENIED;
		end else if (port_power_en[p] && !shed_done_r && want_cur_v_r && act_prio < want_cur_r) begin
			// Make room for a denied port of higher rank; critical is never below
			op_off = 1'b1;
			op_shed = 1'b1;
			st_nxt = `ST_DENIED;
		end else if (port_power_en[p] && mode_r[p] == `MODE_AUTO && !pres_s_r[p]) begin
			// Detach in auto mode
			op_off = 1'b1;
			st_nxt = `ST_POWERED_OFF;
		end else if (port_power_en[p]) begin
			st_nxt = (mode_r[p] == `MODE_FORCE_ON) ? `ST_FORCED_ON : `ST_POWERED_ON;
		end else if (pres_s_r[p] || mode_r[p] == `MODE_FORCE_ON) begin
			// Attach, or forced on without any detection
			if (fits && hold_r == {HW{1'b0}} && !overload) begin
				op_on = 1'b1;
				st_nxt = (mode_r[p] == `MODE_FORCE_ON) ? `ST_FORCED_ON : `ST_POWERED_ON;
			end else begin
				op_deny = 1'b1;
				st_nxt = `ST_DENIED;
			end
		end else begin
			st_nxt = `ST_POWERED_OFF;
		end
	end

	// Command decode and checks
	wire [4:0] cmdw_nxt_op = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
	wire [4:0] c_op = cmdw_nxt_op;
	wire [5:0] c_num = pwdata[`CMD_IDX_MSB:`CMD_IDX_LSB];
	wire [5:0] c_i = c_num - 6'h01;
	wire port_ok = (c_num != 6'h00) && (c_num <= NPORTS);
	wire sup_ok = (c_num != 6'h00) && (c_num <= 6'h03);
	wire [1:0] s_i = c_num[1:0] - 2'h1;
	wire [PW-1:0] c_pw = arg_r[PW-1:0];
	wire pw_fit = (arg_r[31:PW] == {(32-PW){1'b0}});
	wire sw_fit = (arg_r[31:SW] == {(32-SW){1'b0}});
	wire pct_ok = (arg_r[31:7] == 25'h0) && (arg_r[6:0] <= `PCT_MAX);
	wire adj_room = ({1'b0, prov} + {{(TW-PW+1){1'b0}}, grant_r[c_i]}) >=
		({1'b0, gsum_r} + {{(TW-PW+1){1'b0}}, c_pw});
	reg c_ok;
	reg c_restart;
	always @* begin
		c_ok = 1'b0;
		c_restart = 1'b0;
		case (c_op)
			`OP_WRITE_PORT_MODE: c_ok = port_ok && arg_r[31:2] == 30'h0 && arg_r[1:0] != 2'h3;
			`OP_CHANGE_GRANT: c_ok = port_ok && pw_fit && port_power_en[c_i] &&
				(alloc_r == `ALLOC_CONSUME || c_pw <= grant_r[c_i] || adj_room);
			`OP_WRITE_SUPPLY: c_ok = sup_ok && sw_fit;
			`OP_READ_SUPPLY: c_ok = sup_ok;
			`OP_WRITE_RESERVE: c_ok = pct_ok;
			`OP_WRITE_SURGE: c_ok = pct_ok;
			`OP_WRITE_ALLOC: c_ok = (arg_r[31:1] == 31'h0);
			`OP_WRITE_REARM: c_ok = (arg_r[31:2] == 30'h0) && (arg_r[1:0] != 2'h3);
			`OP_WRITE_SITE: c_ok = (arg_r[31:1] == 31'h0);
			`OP_READ_RESERVE, `OP_READ_SURGE, `OP_READ_ALLOC, `OP_READ_REARM, `OP_READ_SITE: c_ok = 1'b1;
			`OP_READ_PORT_STATUS, `OP_READ_PORT_MODE: c_ok = port_ok;
			`OP_WRITE_PORT_ENABLE: c_ok = port_ok && (arg_r[31:1] == 31'h0);
			`OP_WRITE_PORT_PRIO: c_ok = port_ok && (arg_r[31:2] == 30'h0) && (arg_r[1:0] != `PRIO_FORCED);
			default: c_ok = 1'b0;
		endcase
		// Any setting that steers allocation restarts the sweep
		if (c_ok && c_op != `OP_CHANGE_GRANT && !c_op[0] == 1'b0 && c_op <= `OP_WRITE_SITE)
			c_restart = 1'b1;
		if (c_ok && (c_op == `OP_WRITE_PORT_ENABLE || c_op == `OP_WRITE_PORT_PRIO))
			c_restart = 1'b1;
	end

	// Synchronise detect and open pins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pres_m_r <= {NPORTS{1'b0}};
			pres_s_r <= {NPORTS{1'b0}};
			open_m_r <= {NPORTS{1'b0}};
			open_s_r <= {NPORTS{1'b0}};
		end else begin
			pres_m_r <= pd_present_in;
			pres_s_r <= pres_m_r;
			open_m_r <= pd_open_in;
			open_s_r <= open_m_r;
		end
	end

	// Read data captured in the setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			if (paddr == `OFS_CMD)
				prdata <= cmdw_r;
			else if (paddr == `OFS_ARG)
				prdata <= arg_r;
			else if (paddr == `OFS_RESULT)
				prdata <= {24'h0, result_r};
			else if (paddr == `OFS_RDATA)
				prdata <= rdat_r;
			else if (paddr == `OFS_SUM_GRANT)
				prdata <= {{(32-TW){1'b0}}, gsum_r};
			else if (paddr == `OFS_SUM_CONS)
				prdata <= {{(32-TW){1'b0}}, csum_r};
			else if (paddr == `OFS_SUM_PROV)
				prdata <= {{(32-TW){1'b0}}, prov};
			else
				prdata <= 32'h0;
		end
	end

	// Commands, settings and the port sweep
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < NPORTS; k = k + 1) begin
				grant_r[k] <= {PW{1'b0}};
				cons_r[k] <= {PW{1'b0}};
				mode_r[k] <= `MODE_AUTO;
				prio_r[k] <= `PRIO_LOW;
				stat_r[k] <= `ST_POWERED_OFF;
			end
			for (k = 0; k < 3; k = k + 1)
				supply_r[k] <= {SW{1'b0}};
			en_r <= {NPORTS{1'b1}};
			blk_r <= {NPORTS{1'b0}};
			port_power_en <= {NPORTS{1'b0}};
			reserve_r <= `RST_RESERVE;
			surge_r <= `RST_SURGE;
			alloc_r <= `ALLOC_GRANT;
			rearm_r <= `REARM_NOW;
			site_midspan <= `SITE_ENDPOINT;
			gsum_r <= {TW{1'b0}};
			csum_r <= {TW{1'b0}};
			arg_r <= 32'h0;
			cmdw_r <= 32'h0;
			result_r <= `RES_OK;
			rdat_r <= 32'h0;
			hold_r <= {HW{1'b0}};
			scan_port <= 6'h0;
			shed_done_r <= 1'b0;
			shed_lvl_r <= `PRIO_LOW;
			want_v_r <= 1'b0;
			want_r <= `PRIO_LOW;
			want_cur_v_r <= 1'b0;
			want_cur_r <= `PRIO_LOW;
		end else if (cmd_go) begin
			// Command cycle: the sweep stalls so no array sees two writers
			cmdw_r <= pwdata;
			result_r <= c_ok ? `RES_OK : `RES_ERR;
			if (c_ok) begin
				case (c_op)
					`OP_WRITE_PORT_MODE: mode_r[c_i] <= arg_r[1:0];
					`OP_CHANGE_GRANT: begin
						grant_r[c_i] <= c_pw;
						gsum_r <= gsum_r - {{(TW-PW){1'b0}}, grant_r[c_i]} + {{(TW-PW){1'b0}}, c_pw};
					end
					`OP_WRITE_SUPPLY: supply_r[s_i] <= arg_r[SW-1:0];
					`OP_READ_SUPPLY: rdat_r <= {{(32-SW){1'b0}}, supply_r[s_i]};
					`OP_WRITE_RESERVE: reserve_r <= arg_r[6:0];
					`OP_READ_RESERVE: rdat_r <= {25'h0, reserve_r};
					`OP_WRITE_SURGE: surge_r <= arg_r[6:0];
					`OP_READ_SURGE: rdat_r <= {25'h0, surge_r};
					`OP_WRITE_ALLOC: alloc_r <= arg_r[0];
					`OP_READ_ALLOC: rdat_r <= {31'h0, alloc_r};
					`OP_WRITE_REARM: rearm_r <= arg_r[1:0];
					`OP_READ_REARM: rdat_r <= {30'h0, rearm_r};
					`OP_WRITE_SITE: site_midspan <= arg_r[0];
					`OP_READ_SITE: rdat_r <= {31'h0, site_midspan};
					`OP_READ_PORT_STATUS: rdat_r <= {29'h0, stat_r[c_i]};
					`OP_READ_PORT_MODE: rdat_r <= {30'h0, mode_r[c_i]};
					`OP_WRITE_PORT_ENABLE: begin
						en_r[c_i] <= arg_r[0];
						blk_r[c_i] <= 1'b0;
					end
					`OP_WRITE_PORT_PRIO: prio_r[c_i] <= arg_r[1:0];
					default: rdat_r <= rdat_r;
				endcase
			end
			if (c_restart) begin
				// Restart the sweep from port 0, clearing shed and want flags; shed level is kept
				scan_port <= 6'h0;
				shed_done_r <= 1'b0;
				want_v_r <= 1'b0;
				want_cur_v_r <= 1'b0;
			end
		end else begin
			// Argument register write
			if (acc && pwrite && paddr == `OFS_ARG)
				arg_r <= pwdata;
			// Apply the decision for the scanned port
			stat_r[p] <= st_nxt;
			cons_r[p] <= scan_cons_mw;
			csum_r <= csum_r - {{(TW-PW){1'b0}}, cons_r[p]} + {{(TW-PW){1'b0}}, scan_cons_mw};
			if (op_on) begin
				port_power_en[p] <= 1'b1;
				grant_r[p] <= scan_req_mw;
				gsum_r <= gsum_r + req_w;
			end else if (op_off) begin
				port_power_en[p] <= 1'b0;
				grant_r[p] <= {PW{1'b0}};
				gsum_r <= gsum_r - {{(TW-PW){1'b0}}, grant_r[p]};
			end
			if (op_clr_en)
				en_r[p] <= 1'b0;
			if (op_set_blk)
				blk_r[p] <= 1'b1;
			else if (op_clr_blk)
				blk_r[p] <= 1'b0;
			// Back-off after any switch-off, by site
			if (op_off)
				hold_r <= site_midspan ? HOLD_MS : HOLD_EP;
			else if (hold_r != {HW{1'b0}})
				hold_r <= hold_r - {{(HW-1){1'b0}}, 1'b1};
			// Track the highest denied rank of this sweep
			if (op_deny && (!want_v_r || act_prio > want_r)) begin
				want_v_r <= 1'b1;
				want_r <= act_prio;
			end
			if (p == LAST) begin
				// End of sweep: arm preemption and step the shed level
				scan_port <= 6'h0;
				shed_done_r <= 1'b0;
				want_cur_v_r <= want_v_r | (op_deny & ~want_v_r);
				want_cur_r <= (op_deny && (!want_v_r || act_prio > want_r)) ? act_prio : want_r;
				want_v_r <= 1'b0;
				if (!overload)
					shed_lvl_r <= `PRIO_LOW;
				else if (!shed_done_r && !op_shed && shed_lvl_r != `PRIO_CRIT)
					shed_lvl_r <= shed_lvl_r + 2'h1;
			end else begin
				scan_port <= p + 6'h01;
				if (op_shed)
					shed_done_r <= 1'b1;
			end
		end
	end
endmodule

// File: poe_alloc_map.vh
/*
 * Offsets, field positions, codes, reset values and timing counts of the
 * port power allocator. Assumes a 25 MHz pclk and an 8-bit APB byte address.
 */
`ifndef POE_ALLOC_MAP_VH
`define POE_ALLOC_MAP_VH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_ARG 8'h04
`define OFS_RESULT 8'h08
`define OFS_RDATA 8'h0c
`define OFS_SUM_GRANT 8'h10
`define OFS_SUM_CONS 8'h14
`define OFS_SUM_PROV 8'h18

// Command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 4
`define CMD_IDX_LSB 8
`define CMD_IDX_MSB 13

// Command opcodes
`define OP_WRITE_PORT_MODE 5'h01
`define OP_CHANGE_GRANT 5'h02
`define OP_WRITE_SUPPLY 5'h03
`define OP_READ_SUPPLY 5'h04
`define OP_WRITE_RESERVE 5'h05
`define OP_READ_RESERVE 5'h06
`define OP_WRITE_SURGE 5'h07
`define OP_READ_SURGE 5'h08
`define OP_WRITE_ALLOC 5'h09
`define OP_READ_ALLOC 5'h0a
`define OP_WRITE_REARM 5'h0b
`define OP_READ_REARM 5'h0c
`define OP_WRITE_SITE 5'h0d
`define OP_READ_SITE 5'h0e
`define OP_READ_PORT_STATUS 5'h0f
`define OP_WRITE_PORT_ENABLE 5'h10
`define OP_WRITE_PORT_PRIO 5'h11
`define OP_READ_PORT_MODE 5'h12

// Port control modes
`define MODE_AUTO 2'h0
`define MODE_FORCE_ON 2'h1
`define MODE_FORCE_OFF 2'h2

// Allocation, rearm and site codes
`define ALLOC_GRANT 1'h0
`define ALLOC_CONSUME 1'h1
`define REARM_NOW 2'h0
`define REARM_RECONNECT 2'h1
`define REARM_REENABLE 2'h2
`define SITE_ENDPOINT 1'h0
`define SITE_MIDSPAN 1'h1

// Priority levels, forced sits between high and critical
`define PRIO_LOW 2'h0
`define PRIO_HIGH 2'h1
`define PRIO_FORCED 2'h2
`define PRIO_CRIT 2'h3

// Port status codes
`define ST_DISABLED 3'h0
`define ST_POWERED_ON 3'h1
`define ST_POWERED_OFF 3'h2
`define ST_DENIED 3'h3
`define ST_BLOCKED 3'h4
`define ST_FORCED_ON 3'h5
`define ST_FORCED_OFF 3'h6

// Command answers
`define RES_OK 8'h00
`define RES_ERR 8'hff

// Reset values and the percent ceiling
`define RST_RESERVE 7'h00
`define RST_SURGE 7'h0a
`define PCT_MAX 7'h64

// Back-off after a port is switched off, per site
`define CLK_MHZ 25
`define BACKOFF_EP_US 100
`define BACKOFF_MS_US 150
`define BACKOFF_EP_CYC (`BACKOFF_EP_US * `CLK_MHZ)
`define BACKOFF_MS_CYC (`BACKOFF_MS_US * `CLK_MHZ)

`endif

// File: poe_alloc_chk.sv
/* Port-level assertions for the port power allocator.
   Bound to the allocator at the foot of this file; sees its ports only. */
`timescale 1ns/1ps
`include "poe_alloc_map.vh"
module poe_alloc_chk #(
	parameter NPORTS = 48,
	parameter PW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [PW-1:0] scan_req_mw,
	input wire [5:0] scan_port,
	input wire [NPORTS-1:0] port_power_en,
	input wire site_midspan
);
	reg [31:0] arg_r; // Last argument word
	reg [1:0] mode_r [0:NPORTS-1]; // Mirror of port modes
	reg [23:0] sup_r [0:2]; // Mirror of supply outputs
	integer i;
	wire cmd = psel && penable && pwrite && paddr == `OFS_CMD; // Command edge
	wire [4:0] op = pwdata[4:0];
	wire [5:0] idx = pwdata[13:8];
	wire ok = scan_port < NPORTS; // Scan names a real port
	wire [25:0] prov = sup_r[0] + sup_r[1] + sup_r[2]; // Total provided
	wire map = paddr[1:0] == 2'h0 && paddr <= `OFS_SUM_PROV; // Mapped word
	// Mirror the host writes that later checks depend on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arg_r <= 32'h0;
			for (i = 0; i < NPORTS; i = i + 1) begin
				mode_r[i] <= `MODE_AUTO;
			end
			for (i = 0; i < 3; i = i + 1) begin
				sup_r[i] <= 24'h0;
			end
		end else begin
			if (psel && penable && pwrite && paddr == `OFS_ARG) begin
				arg_r <= pwdata;
			end
			if (cmd && op == `OP_WRITE_PORT_MODE && idx != 6'h0 && idx <= NPORTS && arg_r < 32'h3) begin
				mode_r[idx - 6'h1] <= arg_r[1:0];
			end
			if (cmd && op == `OP_WRITE_SUPPLY && idx != 6'h0 && idx < 6'h4 && arg_r < 32'h1000000) begin
				sup_r[idx - 6'h1] <= arg_r[23:0];
			end
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup then access of one transfer
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	property p_unmapped;
		s_access ##0 !map |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped;
		s_access ##0 map |-> !pslverr && pready;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_step;
		!cmd && scan_port != NPORTS - 1 |=> scan_port == $past(scan_port) + 6'h1;
	endproperty
	a_step: assert property (p_step) else $error("scan did not advance");
	property p_wrap;
		!cmd && scan_port == NPORTS - 1 |=> scan_port == 6'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("scan did not wrap");
	property p_site_set;
		cmd && op == `OP_WRITE_SITE && arg_r < 32'h2 |=> site_midspan == arg_r[0];
	endproperty
	a_site_set: assert property (p_site_set) else $error("site not applied");
	property p_site_keep;
		cmd && op == `OP_WRITE_SITE && arg_r > 32'h1 |=> $stable(site_midspan);
	endproperty
	a_site_keep: assert property (p_site_keep) else $error("bad site code applied");
	property p_forced_off;
		!cmd && ok && mode_r[scan_port] == `MODE_FORCE_OFF |=> !port_power_en[$past(scan_port)];
	endproperty
	a_forced_off: assert property (p_forced_off) else $error("forced-off port powered");
	property p_grant_cap;
		!cmd && ok && !port_power_en[scan_port] && scan_req_mw > prov |=> !port_power_en[$past(scan_port)];
	endproperty
	a_grant_cap: assert property (p_grant_cap) else $error("grant beyond provided power");
endmodule
bind poe_port_power_allocator poe_alloc_chk #(.NPORTS(NPORTS), .PW(PW)) u_chk (.*);

// File: pse_ctl_model.sv
/* Model of the port controllers on the scan link.
   The bench sets request, draw and attach per port through this module. */
`timescale 1ns/1ps
module pse_ctl_model #(
	parameter NPORTS = 48,
	parameter PW = 16
) (
	input wire [5:0] scan_port,
	output wire [PW-1:0] scan_req_mw,
	output wire [PW-1:0] scan_cons_mw,
	output reg [NPORTS-1:0] pd_present_in,
	output reg [NPORTS-1:0] pd_open_in
);
	reg [PW-1:0] req_mw [0:NPORTS-1]; // Request each PD states
	reg [PW-1:0] cons_mw [0:NPORTS-1]; // Draw of each PD
	wire hit = scan_port < NPORTS; // Scan names a real port
	integer i;
	// Answer for the port under scan; an empty port draws nothing
	assign scan_req_mw = hit ? req_mw[scan_port] : ~req_mw[0];
	assign scan_cons_mw = hit && pd_present_in[scan_port] ? cons_mw[scan_port] : {PW{1'b0}};
	// Empty ports read open-circuit
	initial begin
		pd_present_in = {NPORTS{1'b0}};
		pd_open_in = {NPORTS{1'b1}};
		for (i = 0; i < NPORTS; i = i + 1) begin
			req_mw[i] = {PW{1'b0}};
			cons_mw[i] = {PW{1'b0}};
		end
	end
	// Attach or pull a PD; pulling shows an open circuit
	task plug(input integer p, input on);
		begin
			pd_present_in[p - 1] <= on;
			pd_open_in[p - 1] <= !on;
		end
	endtask
endmodule

// File: tb_poe_port_power_allocator.sv
/* Self-checking bench for the port power allocator.
   Assumes the map header, zero-wait APB and the far-side model. */
`timescale 1ns/1ps
`include "poe_alloc_map.vh"
module tb_poe_port_power_allocator;
	reg pclk = 1'b0; // 25 MHz bus clock
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, site_midspan;
	wire [47:0] pd_present_in, pd_open_in, port_power_en;
	wire [15:0] scan_req_mw, scan_cons_mw;
	wire [5:0] scan_port;
	integer n_fail = 0; // Mismatches
	integer samples_checked = 0; // Comparisons
	integer i, j;
	reg err; // Last pslverr
	reg [31:0] res, rd, v, w, prov; // Answer, query data, scratch, total provided
	reg [4:0] wop [0:4]; // Setting write opcodes, read is one above
	reg [6:0] vmax [0:4]; // Highest legal code
	always #20 pclk = ~pclk;
	poe_port_power_allocator u_dut (.*);
	pse_ctl_model u_far (.*);
	// Counts and verdict
	task end_of_test;
		begin
			$display("checked %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0) begin
				$display("Finished cleanly");
			end else begin
				$display("Finished with errors");
			end
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One APB transfer, then an idle cycle
	task apb(input wr, input [7:0] a, input [31:0] d, output [31:0] q);
		integer k;
		begin
			k = 0;
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1 && k < 20) begin
				k = k + 1;
				@(posedge pclk);
			end
			q = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
			if (k == 20) begin
				chk(32'h0, 32'h1);
				end_of_test;
			end
		end
	endtask
	// Argument, command, answer, query data
	task cmd(input [4:0] op, input [5:0] idx, input [31:0] arg);
		begin
			apb(1'b1, `OFS_ARG, arg, v);
			apb(1'b1, `OFS_CMD, {18'h0, idx, 3'h0, op}, v);
			apb(1'b0, `OFS_RESULT, 32'h0, res);
			apb(1'b0, `OFS_RDATA, 32'h0, rd);
		end
	endtask
	task st(input [5:0] p, input [2:0] exp);
		begin
			cmd(`OP_READ_PORT_STATUS, p, 32'h0);
			chk(rd, {29'h0, exp});
		end
	endtask
	// Bounded wait for a port's power state
	task wait_pw(input [5:0] p, input val);
		integer k;
		begin
			k = 0;
			while (port_power_en[p - 6'h1] !== val && k < 12000) begin
				k = k + 1;
				@(posedge pclk);
			end
			chk({31'h0, port_power_en[p - 6'h1]}, {31'h0, val});
			if (k == 12000) begin
				end_of_test;
			end
		end
	endtask
	// Power left for a new grant under consumption policy
	function [31:0] room(input [31:0] p, input [31:0] c, input [31:0] pct);
		room = p - c - p * pct / 100;
	endfunction
	initial begin
		v = $urandom(32'heeeb);
		wop[0] = `OP_WRITE_RESERVE;
		wop[1] = `OP_WRITE_SURGE;
		wop[2] = `OP_WRITE_SITE;
		wop[3] = `OP_WRITE_ALLOC;
		wop[4] = `OP_WRITE_REARM;
		vmax[0] = `PCT_MAX;
		vmax[1] = `PCT_MAX;
		vmax[2] = 7'h01;
		vmax[3] = 7'h01;
		vmax[4] = 7'h02;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h1c, 32'h0, rd);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test map done");
		for (i = 0; i < 5; i = i + 1) begin
			for (j = 0; j < 3; j = j + 1) begin
				v = vmax[i] > 2 ? $urandom % 101 : j;
				if (v <= vmax[i]) begin
					w = v;
					cmd(wop[i], 6'h0, w);
					chk(res, `RES_OK);
					cmd(wop[i] + 5'h1, 6'h0, 32'h0);
					chk(rd, w);
				end
			end
			cmd(wop[i], 6'h0, vmax[i] + 7'h1);
			chk(res, `RES_ERR);
			cmd(wop[i] + 5'h1, 6'h0, 32'h0);
			chk(rd, w);
			if (wop[i] == `OP_WRITE_SITE) begin
				chk({31'h0, site_midspan}, w);
			end
		end
		$display("test settings done");
		prov = 0;
		for (i = 1; i < 4; i = i + 1) begin
			w = ($urandom % 199 + 1) * 100;
			prov = prov + w;
			cmd(`OP_WRITE_SUPPLY, i[5:0], w);
			cmd(`OP_READ_SUPPLY, i[5:0], 32'h0);
			chk(rd, w);
		end
		apb(1'b0, `OFS_SUM_PROV, 32'h0, rd);
		chk(rd, prov);
		cmd(`OP_WRITE_SUPPLY, 6'h4, 32'h1);
		chk(res, `RES_ERR);
		cmd(`OP_WRITE_ALLOC, 6'h0, `ALLOC_GRANT);
		u_far.req_mw[1] <= prov[15:0] + 16'h1;
		u_far.plug(2, 1'b1);
		repeat (4000) @(posedge pclk);
		st(6'h2, `ST_DENIED);
		u_far.req_mw[1] <= prov[15:0];
		wait_pw(6'h2, 1'b1);
		cmd(`OP_CHANGE_GRANT, 6'h2, prov - 1);
		chk(res, `RES_OK);
		apb(1'b0, `OFS_SUM_GRANT, 32'h0, rd);
		chk(rd, prov - 1);
		cmd(`OP_CHANGE_GRANT, 6'h5, 32'h1);
		chk(res, `RES_ERR);
		u_far.plug(2, 1'b0);
		wait_pw(6'h2, 1'b0);
		$display("test grant done");
		u_far.req_mw[0] <= 16'h0010;
		cmd(`OP_WRITE_PORT_MODE, 6'h1, `MODE_FORCE_ON);
		wait_pw(6'h1, 1'b1);
		st(6'h1, `ST_FORCED_ON);
		cmd(`OP_WRITE_PORT_MODE, 6'h1, `MODE_FORCE_OFF);
		wait_pw(6'h1, 1'b0);
		st(6'h1, `ST_FORCED_OFF);
		cmd(`OP_WRITE_PORT_MODE, 6'h31, `MODE_AUTO);
		chk(res, `RES_ERR);
		cmd(`OP_WRITE_PORT_MODE, 6'h1, 32'h3);
		chk(res, `RES_ERR);
		cmd(`OP_READ_PORT_MODE, 6'h1, 32'h0);
		chk(rd, `MODE_FORCE_OFF);
		cmd(`OP_WRITE_PORT_MODE, 6'h1, `MODE_AUTO);
		$display("test mode done");
		u_far.req_mw[2] <= 16'h0064;
		u_far.cons_mw[2] <= 16'h0032;
		u_far.plug(3, 1'b1);
		wait_pw(6'h3, 1'b1);
		for (i = 0; i < 3; i = i + 1) begin
			cmd(`OP_WRITE_REARM, 6'h0, i);
			u_far.cons_mw[2] <= 16'h0065;
			wait_pw(6'h3, 1'b0);
			u_far.cons_mw[2] <= 16'h0032;
			if (i > 0) begin
				repeat (4000) @(posedge pclk);
				st(6'h3, i == 1 ? `ST_BLOCKED : `ST_DISABLED);
			end
			if (i == 1) begin
				u_far.plug(3, 1'b0);
				repeat (100) @(posedge pclk);
				u_far.plug(3, 1'b1);
			end
			if (i == 2) begin
				cmd(`OP_WRITE_PORT_ENABLE, 6'h3, 32'h1);
			end
			wait_pw(6'h3, 1'b1);
		end
		$display("test rearm done");
		w = $urandom % 51;
		cmd(`OP_WRITE_RESERVE, 6'h0, w);
		cmd(`OP_WRITE_ALLOC, 6'h0, `ALLOC_CONSUME);
		w = room(prov, 32'h32, w);
		u_far.req_mw[3] <= w[15:0] + 16'h1;
		u_far.plug(4, 1'b1);
		repeat (4000) @(posedge pclk);
		st(6'h4, `ST_DENIED);
		u_far.req_mw[3] <= w[15:0];
		wait_pw(6'h4, 1'b1);
		$display("test reserve done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({31'h0, |port_power_en}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		cmd(`OP_READ_SURGE, 6'h0, 32'h0);
		chk(rd, `RST_SURGE);
		apb(1'b0, `OFS_SUM_PROV, 32'h0, rd);
		chk(rd, 32'h0);
		$display("test reset done");
		end_of_test;
	end
endmodule
